// >>> hdl/five_stage_pipe.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module five_stage_pipe (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // instruction cache and tlb
   output logic [31:0]      imem_addr,
   output logic [pipe_pkg::ICACHE_IDXW-1:0] icache_index,
   input  wire logic [31:0] icache_rdata,
   input  wire logic [19:0] icache_tag,
   input  wire logic [19:0] itlb_pfn,
   // register file
   output logic [4:0]       rf_raddr_a,
   output logic [4:0]       rf_raddr_b,
   input  wire logic [31:0] rf_rdata_a,
   input  wire logic [31:0] rf_rdata_b,
   output logic             rf_we,
   output logic [4:0]       rf_waddr,
   output logic [31:0]      rf_wdata,
   // data cache and tlb
   output logic             dcache_re,
   output logic [31:0]      dcache_addr,
   input  wire logic [31:0] dcache_rdata,
   input  wire logic [19:0] dcache_tag,
   input  wire logic [19:0] dtlb_pfn,
   output logic             dcache_we,
   output logic [31:0]      dcache_waddr,
   output logic [31:0]      dcache_wdata
);
   import pipe_pkg::*;

   // fetch and register-fetch state
   logic [31:0]     pc_reg;
   logic            rf_v_reg;
   logic [31:0]     rf_ir_reg;
   logic [31:0]     rf_pc_reg;
   logic [19:0]     rf_tag_reg;
   logic [19:0]     rf_pfn_reg;
   logic            rf_bd_reg;
   // execute latches
   logic [OPW-1:0]  ex_op_reg;
   logic [31:0]     ex_a_reg;
   logic [31:0]     ex_b_reg;
   logic [31:0]     ex_imm_reg;
   logic [31:0]     ex_link_reg;
   logic [4:0]      ex_rd_reg;
   logic [31:0]     ex_pc_reg;
   logic            ex_bd_reg;
   // data-cache latches
   logic [OPW-1:0]  dc_op_reg;
   logic [31:0]     dc_res_reg;
   logic [31:0]     dc_sd_reg;
   logic [4:0]      dc_rd_reg;
   logic            dc_trap_reg;
   logic [31:0]     dc_epc_reg;
   logic            dc_bd_reg;
   logic            dc_ld2_reg;
   // write-back latches
   logic            wb_rf_we_reg;
   logic [4:0]      wb_rd_reg;
   logic [31:0]     wb_res_reg;
   logic            wb_dc_we_reg;
   logic [31:0]     wb_daddr_reg;
   logic [31:0]     wb_sd_reg;
   logic            wb_trap_reg;
   logic [31:0]     wb_epc_reg;
   logic            wb_bd_reg;
   // software visible state
   logic            run_reg;
   logic            exl_reg;
   logic            bd_reg;
   logic [4:0]      cause_reg;
   logic [31:0]     epc_reg;
   logic            pready_reg;
   logic            pslverr_reg;
   logic [31:0]     prdata_reg;

   // register-fetch decode
   wire [5:0]  rf_opc  = rf_ir_reg[31:26];
   wire [5:0]  rf_fn   = rf_ir_reg[5:0];
   wire [4:0]  src_a   = rf_ir_reg[25:21];
   wire [4:0]  src_b   = rf_ir_reg[20:16];
   wire [4:0]  dst_rd  = rf_ir_reg[15:11];
   wire [31:0] sext    = {{16{rf_ir_reg[15]}}, rf_ir_reg[15:0]};
   wire        is_spec = rf_opc == OPC_SPECIAL;
   wire        d_add   = is_spec && rf_fn == FN_ADD;
   wire        d_jump_link_register_op  = is_spec && rf_fn == FN_JUMP_LINK_REGISTER_OP;
   wire        d_tlt   = is_spec && rf_fn == FN_TLT;
   wire        d_beq   = rf_opc == OPC_BEQ;
   wire        d_lw    = rf_opc == OPC_LW;
   wire        d_sw    = rf_opc == OPC_SW;
   // tag check of the word fetched last cycle
   wire        rf_hit  = rf_tag_reg == rf_pfn_reg;
   wire        rf_ok   = rf_v_reg && rf_hit;

   // destination: jump_link_register_op with no rd defaults to the link register
   wire [4:0] jump_link_register_op_rd = (dst_rd == 5'h00) ? LINK_REG : dst_rd;
   wire [4:0] dec_rd  = d_jump_link_register_op ? jump_link_register_op_rd : (d_lw ? src_b : dst_rd);
   wire [OPW-1:0] dec_op;
   assign dec_op[OP_ADD]  = d_add;
   assign dec_op[OP_LINK] = d_jump_link_register_op;
   assign dec_op[OP_TLT]  = d_tlt;
   assign dec_op[OP_LD]   = d_lw;
   assign dec_op[OP_ST]   = d_sw;

   // execute stage arithmetic
   wire ex_wr = ex_op_reg[OP_ADD] | ex_op_reg[OP_LINK] | ex_op_reg[OP_LD];
   wire ex_mem = ex_op_reg[OP_LD] | ex_op_reg[OP_ST];
   wire [31:0] sum  = ex_a_reg + ex_b_reg;
   wire [31:0] diff = ex_a_reg - ex_b_reg;
   wire [31:0] data_virtual_address_calc  = ex_a_reg + ex_imm_reg;
   wire [31:0] alu_res = ex_mem ? data_virtual_address_calc
                       : (ex_op_reg[OP_LINK] ? ex_link_reg : sum);
   // signed less-than from the operand and difference signs
   wire lt = (ex_a_reg[31] ^ ex_b_reg[31]) ? ex_a_reg[31]
                                           : diff[31];
   // store data shifted into its byte lanes
   wire [4:0]  sh_amt = {data_virtual_address_calc[1:0], 3'b000};
   wire [31:0] st_aln = ex_b_reg << sh_amt;

   // data-cache stage
   wire dc_wr = dc_op_reg[OP_ADD] | dc_op_reg[OP_LINK] | dc_op_reg[OP_LD];
   wire        dc_hit = dcache_tag == dtlb_pfn;
   wire [4:0]  ld_sh  = {dc_res_reg[1:0], 3'b000};
   wire [31:0] ld_aln = dcache_rdata >> ld_sh;
   wire [31:0] dc_val = dc_op_reg[OP_LD] ? ld_aln : dc_res_reg;

   // load sits in the dcache stage for two cycles; front end frozen
   wire ld_hold = dc_op_reg[OP_LD] && !dc_ld2_reg;
   // store still owns the dcache in writeback next cycle
   wire slip_st = dc_op_reg[OP_ST] && ex_mem;
   // consumer right behind a load waits in register fetch
   wire slip_lu = rf_v_reg && ex_op_reg[OP_LD]
                  && ex_rd_reg != 5'h00
                  && (ex_rd_reg == src_a || ex_rd_reg == src_b);
   wire ex_go   = !ld_hold && !slip_st;
   wire rf_go   = ex_go && !slip_lu;
   wire trap_now = ex_go && ex_op_reg[OP_TLT] && lt;

   // bypass, youngest first; all inputs passed so the wires track them
   function automatic logic [31:0] fwd(
      input logic [4:0]  src,
      input logic [31:0] rfd,
      input logic [31:0] exv,
      input logic [31:0] dcv,
      input logic        exw,
      input logic        dcw,
      input logic [4:0]  exd,
      input logic [4:0]  dcd,
      input logic        wbw,
      input logic [4:0]  wbd,
      input logic [31:0] wbv
   );
      logic [31:0] r;
      r = rfd;
      if (src == 5'h00) begin
         r = 32'h0000_0000;
      end else if (exw && exd == src) begin
         r = exv;
      end else if (dcw && dcd == src) begin
         r = dcv;
      end else if (wbw && wbd == src) begin
         r = wbv;
      end
      return r;
   endfunction

   // loads in execute are never forwarded: slip_lu covers them
   wire ex_fw = ex_wr && !ex_op_reg[OP_LD];
   wire [31:0] opa = fwd(src_a, rf_rdata_a, alu_res, dc_val,
                         ex_fw, dc_wr, ex_rd_reg, dc_rd_reg,
                         wb_rf_we_reg, wb_rd_reg, wb_res_reg);
   wire [31:0] opb = fwd(src_b, rf_rdata_b, alu_res, dc_val,
                         ex_fw, dc_wr, ex_rd_reg, dc_rd_reg,
                         wb_rf_we_reg, wb_rd_reg, wb_res_reg);

   // branch resolution in register fetch; pc_reg already holds the
   // delay slot address, so the slot is fetched either way
   wire        beq_tk  = d_beq && (opa == opb);
   wire [31:0] beq_tgt = pc_reg + {sext[29:0], 2'b00};
   wire        rf_br   = rf_ok && (d_jump_link_register_op || d_beq);
   wire [31:0] rf_link = rf_pc_reg + LINK_OFS;

   // next fetch address
   wire [31:0] pc_next =
        trap_now              ? EXC_VECTOR
      : !rf_go                ? pc_reg
      : (rf_v_reg && !rf_hit) ? rf_pc_reg
      : (rf_ok && d_jump_link_register_op)     ? opa
      : (rf_ok && beq_tk)     ? beq_tgt
      : run_reg               ? pc_reg + PC_STEP
      :                         pc_reg;

   // apb decode
   wire apb_acc = psel && penable && !pready_reg;
   // writes land on the edge that samples pready high
   wire apb_wr  = psel && penable && pready_reg && pwrite;
   wire sel_ctl = paddr == CTRL_OFS;
   wire sel_st  = paddr == STATUS_OFS;
   wire sel_epc = paddr == EPC_OFS;
   wire sel_ok  = sel_ctl || sel_st || sel_epc;
   wire [31:0] status_word = {25'h0, cause_reg,
                              bd_reg, exl_reg};
   wire [31:0] rd_mux = sel_ctl ? {31'h0, run_reg}
                      : sel_st  ? status_word
                      : sel_epc ? epc_reg
                      :           32'h0000_0000;
   wire exl_clr = apb_wr && sel_st && pwdata[STAT_EXL_BIT];

   // fetch stage
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pc_reg   <= RESET_PC;
         rf_v_reg <= 1'b0;
      end else begin
         pc_reg <= pc_next;
         if (trap_now) begin
            rf_v_reg <= 1'b0;
         end else if (rf_go) begin
            rf_v_reg <= run_reg && !(rf_v_reg && !rf_hit);
         end
      end
   end

   // fetched word, its pc and both tags into register fetch
   always_ff @(posedge clk_sys) begin
      if (rf_go) begin
         rf_ir_reg  <= icache_rdata;
         rf_pc_reg  <= pc_reg;
         rf_tag_reg <= icache_tag;
         rf_pfn_reg <= itlb_pfn;
         rf_bd_reg  <= rf_br;
      end
   end

   // register fetch to execute
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ex_op_reg <= '0;
      end else if (trap_now || (ex_go && !(rf_go && rf_ok))) begin
         ex_op_reg <= '0;
      end else if (rf_go) begin
         ex_op_reg <= dec_op;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rf_go) begin
         ex_a_reg    <= opa;
         ex_b_reg    <= opb;
         ex_imm_reg  <= sext;
         ex_link_reg <= rf_link;
         ex_rd_reg   <= dec_rd;
         ex_pc_reg   <= rf_pc_reg;
         ex_bd_reg   <= rf_bd_reg;
      end
   end

   // execute to data cache
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dc_op_reg   <= '0;
         dc_trap_reg <= 1'b0;
         dc_ld2_reg  <= 1'b0;
      end else begin
         dc_ld2_reg <= ld_hold;
         if (ex_go) begin
            dc_op_reg   <= ex_op_reg;
            dc_trap_reg <= trap_now;
         end else if (!ld_hold) begin
            dc_op_reg   <= '0;
            dc_trap_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ex_go) begin
         dc_res_reg <= alu_res;
         dc_sd_reg  <= st_aln;
         dc_rd_reg  <= ex_rd_reg;
         dc_epc_reg <= ex_pc_reg;
         dc_bd_reg  <= ex_bd_reg;
      end
   end

   // data cache to write back; first load cycle sends a bubble
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wb_rf_we_reg <= 1'b0;
         wb_dc_we_reg <= 1'b0;
         wb_trap_reg  <= 1'b0;
      end else begin
         wb_rf_we_reg <= !ld_hold && dc_wr
                         && dc_rd_reg != 5'h00;
         wb_dc_we_reg <= dc_op_reg[OP_ST] && dc_hit;
         wb_trap_reg  <= dc_trap_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      wb_rd_reg    <= dc_rd_reg;
      wb_res_reg   <= dc_val;
      wb_daddr_reg <= dc_res_reg;
      wb_sd_reg    <= dc_sd_reg;
      wb_epc_reg   <= dc_epc_reg;
      wb_bd_reg    <= dc_bd_reg;
   end

   // exception state; a trap arriving with a clear keeps exl set
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         exl_reg   <= 1'b0;
         bd_reg    <= 1'b0;
         cause_reg <= 5'h00;
         epc_reg   <= RESET_PC;
      end else if (wb_trap_reg) begin
         exl_reg   <= 1'b1;
         bd_reg    <= wb_bd_reg;
         cause_reg <= TRAP_CAUSE;
         epc_reg   <= wb_bd_reg ? wb_epc_reg - PC_STEP
                                : wb_epc_reg;
      end else if (exl_clr) begin
         exl_reg <= 1'b0;
      end
   end

   // apb slave: one wait state, answer from flops
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         run_reg     <= CTRL_RUN_RST;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= apb_acc;
         pslverr_reg <= apb_acc && !sel_ok;
         prdata_reg  <= (apb_acc && !pwrite) ? rd_mux
                                             : 32'h0000_0000;
         if (apb_wr && sel_ctl) begin
            run_reg <= pwdata[CTRL_RUN_BIT];
         end
      end
   end

   // outputs, each a flop or a slice of one
   assign pready       = pready_reg;
   assign prdata       = prdata_reg;
   assign pslverr      = pslverr_reg;
   assign imem_addr    = pc_reg;
   assign icache_index = pc_reg[ICACHE_IDXW-1:0];
   assign rf_raddr_a   = rf_ir_reg[25:21];
   assign rf_raddr_b   = rf_ir_reg[20:16];
   assign rf_we        = wb_rf_we_reg;
   assign rf_waddr     = wb_rd_reg;
   assign rf_wdata     = wb_res_reg;
   assign dcache_re    = dc_op_reg[OP_LD];
   assign dcache_addr  = dc_res_reg;
   assign dcache_we    = wb_dc_we_reg;
   assign dcache_waddr = wb_daddr_reg;
   assign dcache_wdata = wb_sd_reg;

endmodule

// >>> hdl/pipe_pkg.sv
package pipe_pkg;
   // instruction encodings
   localparam logic [5:0] OPC_SPECIAL = 6'h00;
   localparam logic [5:0] OPC_BEQ     = 6'h04;
   localparam logic [5:0] OPC_LW      = 6'h23;
   localparam logic [5:0] OPC_SW      = 6'h2B;
   localparam logic [5:0] FN_ADD      = 6'h20;
   localparam logic [5:0] FN_JUMP_LINK_REGISTER_OP     = 6'h09;
   localparam logic [5:0] FN_TLT      = 6'h32;
   // operation bits carried down the pipe
   localparam int OPW     = 5;
   localparam int OP_ADD  = 0;
   localparam int OP_LINK = 1;
   localparam int OP_TLT  = 2;
   localparam int OP_LD   = 3;
   localparam int OP_ST   = 4;
   // pipe cycle clock runs at this multiple of the master clock
   localparam int PCLK_PER_MCLK = 4;
   localparam logic [31:0] PC_STEP     = 32'h0000_0004;
   localparam logic [31:0] LINK_OFS    = 32'h0000_0008;
   localparam logic [4:0]  LINK_REG    = 5'h1F;
   localparam int          ICACHE_IDXW = 11;
   // exception handling
   localparam logic [4:0]  TRAP_CAUSE  = 5'h0D;
   localparam logic [31:0] EXC_VECTOR  = 32'h0000_0080;
   localparam logic [31:0] RESET_PC    = 32'h0000_0000;
   // apb register map
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] EPC_OFS    = 8'h08;
   localparam int CTRL_RUN_BIT  = 0;
   localparam int STAT_EXL_BIT  = 0;
   localparam int STAT_BD_BIT   = 1;
   localparam int STAT_CAUSE_LO = 2;
   localparam logic CTRL_RUN_RST = 1'b0;
endpackage

// >>> verif/cache_rf_model.sv
`timescale 1ns/1ps
module cache_rf_model (
   // clock
   input  wire logic        clk_sys,
   // instruction side
   input  wire logic [31:0] imem_addr,
   output logic [31:0]      icache_rdata,
   output logic [19:0]      icache_tag,
   output logic [19:0]      itlb_pfn,
   // register file
   input  wire logic [4:0]  rf_raddr_a,
   input  wire logic [4:0]  rf_raddr_b,
   output logic [31:0]      rf_rdata_a,
   output logic [31:0]      rf_rdata_b,
   input  wire logic        rf_we,
   input  wire logic [4:0]  rf_waddr,
   input  wire logic [31:0] rf_wdata,
   // data side
   input  wire logic        dcache_re,
   input  wire logic [31:0] dcache_addr,
   output logic [31:0]      dcache_rdata,
   output logic [19:0]      dcache_tag,
   output logic [19:0]      dtlb_pfn,
   input  wire logic        dcache_we,
   input  wire logic [31:0] dcache_waddr,
   input  wire logic [31:0] dcache_wdata
);
   logic [31:0] imem [0:255];
   logic [31:0] dmem [0:255];
   logic [31:0] regs [0:31];
   logic [31:0] dword;
   assign icache_rdata = imem[imem_addr[9:2]];
   assign icache_tag   = imem_addr[31:12];
   assign itlb_pfn     = imem_addr[31:12];
   assign rf_rdata_a   = (rf_raddr_a == 5'h00) ? 32'h0 : regs[rf_raddr_a];
   assign rf_rdata_b   = (rf_raddr_b == 5'h00) ? 32'h0 : regs[rf_raddr_b];
   assign dword        = dmem[dcache_addr[9:2]];
   // unread data lines show the inverse, never a stale word
   assign dcache_rdata = dcache_re ? dword : ~dword;
   assign dcache_tag   = dcache_addr[31:12];
   assign dtlb_pfn     = dcache_addr[31:12];
   always @(posedge clk_sys) begin
      if (rf_we) begin
         regs[rf_waddr] <= rf_wdata;
      end
      if (dcache_we) begin
         dmem[dcache_waddr[9:2]] <= dcache_wdata;
      end
   end
endmodule

// >>> verif/five_stage_cpu_pipeline_tb.sv
`timescale 1ns/1ps
module five_stage_cpu_pipeline_tb;
   import pipe_pkg::*;
   typedef struct packed {
      logic [4:0]  r;
      logic [31:0] v;
   } row_t;
   logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
   logic        rf_we, dcache_re, dcache_we, err;
   logic [7:0]  paddr;
   logic [4:0]  rf_raddr_a, rf_raddr_b, rf_waddr;
   logic [19:0] icache_tag, itlb_pfn, dcache_tag, dtlb_pfn;
   logic [31:0] pwdata, prdata, imem_addr, icache_rdata, rf_rdata_a;
   logic [31:0] rf_rdata_b, rf_wdata, dcache_addr, dcache_rdata;
   logic [31:0] dcache_waddr, dcache_wdata, rd, last;
   logic [ICACHE_IDXW-1:0] icache_index;
   logic [31:0] fetched [$];
   int          n_mismatch, compares, cyc;
   row_t rows [12] = '{'{5'd4, 32'h0C}, '{5'd5, 32'h18}, '{5'd6, 32'h100},
      '{5'd7, 32'h105}, '{5'd8, 32'h105}, '{5'd9, 32'h0A}, '{5'd10, 32'h0},
      '{5'd11, 32'h40}, '{5'd12, 32'h0E}, '{5'd13, 32'h0}, '{5'd14, 32'h0},
      '{5'd31, 32'h2C}};
   logic [31:0] path [14] = '{32'h04, 32'h08, 32'h0C, 32'h10, 32'h14,
      32'h18, 32'h1C, 32'h24, 32'h28, 32'h40, 32'h44, 32'h48, 32'h80, 32'h84};
   five_stage_pipe dut (
      .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .imem_addr(imem_addr),
      .icache_index(icache_index), .icache_rdata(icache_rdata),
      .icache_tag(icache_tag), .itlb_pfn(itlb_pfn),
      .rf_raddr_a(rf_raddr_a), .rf_raddr_b(rf_raddr_b),
      .rf_rdata_a(rf_rdata_a), .rf_rdata_b(rf_rdata_b), .rf_we(rf_we),
      .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .dcache_re(dcache_re),
      .dcache_addr(dcache_addr), .dcache_rdata(dcache_rdata),
      .dcache_tag(dcache_tag), .dtlb_pfn(dtlb_pfn), .dcache_we(dcache_we),
      .dcache_waddr(dcache_waddr), .dcache_wdata(dcache_wdata));
   cache_rf_model mdl (
      .clk_sys(clk_sys), .imem_addr(imem_addr), .icache_rdata(icache_rdata),
      .icache_tag(icache_tag), .itlb_pfn(itlb_pfn),
      .rf_raddr_a(rf_raddr_a), .rf_raddr_b(rf_raddr_b),
      .rf_rdata_a(rf_rdata_a), .rf_rdata_b(rf_rdata_b), .rf_we(rf_we),
      .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .dcache_re(dcache_re),
      .dcache_addr(dcache_addr), .dcache_rdata(dcache_rdata),
      .dcache_tag(dcache_tag), .dtlb_pfn(dtlb_pfn), .dcache_we(dcache_we),
      .dcache_waddr(dcache_waddr), .dcache_wdata(dcache_wdata));
   always #20 clk_sys = ~clk_sys;
   function automatic logic [31:0] rop(input int s, t, d, logic [5:0] f);
      return {OPC_SPECIAL, 5'(s), 5'(t), 5'(d), 5'h00, f};
   endfunction
   function automatic logic [31:0] iop(input logic [5:0] o, int s, t,
                                       logic [15:0] im);
      return {o, 5'(s), 5'(t), im};
   endfunction
   task automatic end_of_test();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk_word(input string s, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_bit(input string s, logic e, logic g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", s, e, g);
      end
   endtask
   // entered just after a rising edge; one idle cycle after each transfer
   task automatic apb(input logic w, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge clk_sys);
         n++;
      end
      chk_bit("pready", 1'b1, pready);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // each change of fetch address, in order of appearance
   always @(posedge clk_sys) begin
      if (rstn === 1'b1 && imem_addr !== last) begin
         fetched.push_back(imem_addr);
         last = imem_addr;
      end
   end
   initial begin
      clk_sys = 1'b0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      last = 32'h0;
      for (int i = 0; i < 256; i++) begin
         mdl.imem[i] = 32'h0;
         mdl.dmem[i] = 32'h0;
         mdl.regs[i % 32] = 32'h0;
      end
      mdl.regs[1] = 32'h5;
      mdl.regs[2] = 32'h7;
      mdl.regs[3] = 32'h10;
      mdl.regs[11] = 32'h40;
      mdl.dmem[4] = 32'h100;
      mdl.imem[0] = rop(1, 2, 4, FN_ADD);
      mdl.imem[1] = rop(4, 4, 5, FN_ADD);
      mdl.imem[2] = iop(OPC_LW, 3, 6, 16'h0000);
      mdl.imem[3] = rop(6, 1, 7, FN_ADD);
      mdl.imem[4] = iop(OPC_SW, 3, 7, 16'h0004);
      mdl.imem[5] = iop(OPC_LW, 3, 8, 16'h0004);
      mdl.imem[6] = iop(OPC_BEQ, 1, 1, 16'h0002);
      mdl.imem[7] = rop(1, 1, 9, FN_ADD);
      mdl.imem[8] = rop(1, 1, 10, FN_ADD);
      mdl.imem[9] = rop(11, 0, 0, FN_JUMP_LINK_REGISTER_OP);
      mdl.imem[10] = rop(2, 2, 12, FN_ADD);
      mdl.imem[11] = rop(1, 1, 13, FN_ADD);
      mdl.imem[16] = rop(1, 2, 0, FN_TLT);
      mdl.imem[17] = rop(1, 1, 14, FN_ADD);
      mdl.imem[32] = iop(OPC_BEQ, 0, 0, 16'hFFFF);
      repeat (20) @(posedge clk_sys);
      chk_word("pc in reset", RESET_PC, imem_addr);
      chk_bit("rf_we in reset", 1'b0, rf_we);
      chk_bit("dcache_we in reset", 1'b0, dcache_we);
      rstn <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, CTRL_OFS, 32'h0, rd, err);
      chk_word("ctrl reset", 32'(CTRL_RUN_RST), rd);
      chk_word("pc idle", RESET_PC, imem_addr);
      apb(1'b1, CTRL_OFS, 32'h1, rd, err);
      for (int i = 0; i < 300 && imem_addr !== EXC_VECTOR; i++) begin
         @(posedge clk_sys);
      end
      // drain: trap reaches write-back within the pipe depth
      repeat (8) @(posedge clk_sys);
      foreach (rows[i]) begin
         chk_word($sformatf("r%0d", rows[i].r), rows[i].v,
                  mdl.regs[rows[i].r]);
      end
      foreach (path[i]) begin
         chk_word("fetch", path[i], fetched[i]);
      end
      chk_word("stored word", 32'h105, mdl.dmem[5]);
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      chk_word("status", 32'({TRAP_CAUSE, 2'b01}), rd & 32'h7F);
      apb(1'b0, EPC_OFS, 32'h0, rd, err);
      chk_word("epc", 32'h40, rd);
      apb(1'b0, 8'h0C, 32'h0, rd, err);
      chk_bit("unmapped error", 1'b1, err);
      chk_word("unmapped data", 32'h0, rd);
      apb(1'b1, EPC_OFS, 32'hFFFF_FFFF, rd, err);
      apb(1'b0, EPC_OFS, 32'h0, rd, err);
      chk_word("epc read-only", 32'h40, rd);
      apb(1'b1, STATUS_OFS, 32'h1, rd, err);
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      chk_bit("exl cleared", 1'b0, rd[STAT_EXL_BIT]);
      // reset again while the loop at the vector is running
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_word("pc mid reset", RESET_PC, imem_addr);
      chk_bit("rf_we mid reset", 1'b0, rf_we);
      chk_bit("dcache_re mid reset", 1'b0, dcache_re);
      rstn <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, CTRL_OFS, 32'h0, rd, err);
      chk_word("run after reset", 32'(CTRL_RUN_RST), rd);
      chk_word("pc held", RESET_PC, imem_addr);
      end_of_test();
   end
endmodule

// >>> verif/pipe_checker_asserts.sv
`timescale 1ns/1ps
module pipe_checker (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rstn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // fetch
   input wire logic [31:0] imem_addr,
   input wire logic [pipe_pkg::ICACHE_IDXW-1:0] icache_index,
   // write-back and data cache
   input wire logic        rf_we,
   input wire logic [4:0]  rf_waddr,
   input wire logic        dcache_re,
   input wire logic [31:0] dcache_addr,
   input wire logic [19:0] dcache_tag,
   input wire logic [19:0] dtlb_pfn,
   input wire logic        dcache_we
);
   import pipe_pkg::*;
   logic hit_q;
   // store writes a cycle after its tag compare
   always_ff @(posedge clk_sys) begin
      hit_q <= (dcache_tag == dtlb_pfn);
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_reset_empty;
      $rose(rstn) |-> !rf_we && !dcache_we && !dcache_re
         && !pready && imem_addr == RESET_PC;
   endproperty
   a_reset_empty: assert property (p_reset_empty)
      else $error("pipe not empty after reset");
   property p_index;
      icache_index == imem_addr[ICACHE_IDXW-1:0];
   endproperty
   a_index: assert property (p_index)
      else $error("icache index not low pc bits");
   property p_load_two;
      $rose(dcache_re) |=> dcache_re;
   endproperty
   a_load_two: assert property (p_load_two)
      else $error("load left dcache stage early");
   property p_load_addr;
      $rose(dcache_re) |=> $stable(dcache_addr);
   endproperty
   a_load_addr: assert property (p_load_addr)
      else $error("data address moved during load");
   property p_load_wb;
      $rose(dcache_re) |-> ##2 rf_we;
   endproperty
   a_load_wb: assert property (p_load_wb)
      else $error("load result not written back");
   property p_store_hit;
      dcache_we |-> hit_q;
   endproperty
   a_store_hit: assert property (p_store_hit)
      else $error("store written on a miss");
   property p_no_r0;
      rf_we |-> rf_waddr != 5'h00;
   endproperty
   a_no_r0: assert property (p_no_r0)
      else $error("write strobe to register zero");
   property p_apb_answer;
      psel && penable && !pready |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer late");
   property p_apb_pulse;
      pready |=> !pready ##1 !pready;
   endproperty
   a_apb_pulse: assert property (p_apb_pulse)
      else $error("pready not a pulse");
   property p_apb_idle;
      !pready |-> prdata == 32'h0 && !pslverr;
   endproperty
   a_apb_idle: assert property (p_apb_idle)
      else $error("apb outputs set without pready");
endmodule
bind five_stage_pipe pipe_checker chk (
   .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .imem_addr(imem_addr), .icache_index(icache_index), .rf_we(rf_we),
   .rf_waddr(rf_waddr), .dcache_re(dcache_re), .dcache_addr(dcache_addr),
   .dcache_tag(dcache_tag), .dtlb_pfn(dtlb_pfn), .dcache_we(dcache_we)
);
